// ===== hw/tpio_pkg.sv
package tpio_pkg;

  // register offsets on the plain software port
  localparam logic [5:0] TPIO_OFS_FIRST_DATA  = 6'h1b;
  localparam logic [5:0] TPIO_OFS_FIRST_CTRL  = 6'h1a;
  localparam logic [5:0] TPIO_OFS_FIRST_PINS  = 6'h19;
  localparam logic [5:0] TPIO_OFS_INPUT_PINS  = 6'h16;
  localparam logic [5:0] TPIO_OFS_THIRD_DATA  = 6'h12;
  localparam logic [5:0] TPIO_OFS_THIRD_DIR   = 6'h11;
  localparam logic [5:0] TPIO_OFS_THIRD_PINS  = 6'h10;
  localparam logic [5:0] TPIO_OFS_PULLUP_CTRL = 6'h07;

  // widths
  localparam int TPIO_ADDR_W  = 6;
  localparam int TPIO_DATA_W  = 8;
  localparam int TPIO_FIRST_W = 4;
  localparam int TPIO_WIDE_W  = 8;

  // field positions
  localparam int TPIO_LED_BIT       = 2;
  localparam int TPIO_HC_BIT        = 2;
  localparam int TPIO_COMMON_PU_BIT = 7;

  // bits of the first port that are bidirectional (all but the led line)
  localparam logic [3:0] TPIO_FIRST_BIDIR_MASK = 4'hb;

  // reset values
  localparam logic [3:0] TPIO_FIRST_DATA_RST = 4'h0;
  localparam logic [3:0] TPIO_FIRST_CTRL_RST = 4'h0;
  localparam logic [7:0] TPIO_THIRD_DATA_RST = 8'h00;
  localparam logic [7:0] TPIO_THIRD_DIR_RST  = 8'h00;
  localparam logic       TPIO_COMMON_PU_RST  = 1'b0;
  localparam logic [7:0] TPIO_RDATA_RST      = 8'h00;

  // register-port request carried as one bundle
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tpio_req_t;

  // software-visible state of the top module
  typedef struct packed {
    logic [3:0] first_data;
    logic [3:0] first_ctrl;
    logic [7:0] third_data;
    logic [7:0] third_dir;
    logic       common_pu;
    logic [7:0] rdata;
  } tpio_regs_t;

  localparam tpio_regs_t TPIO_REGS_RST = '{
    first_data: TPIO_FIRST_DATA_RST,
    first_ctrl: TPIO_FIRST_CTRL_RST,
    third_data: TPIO_THIRD_DATA_RST,
    third_dir:  TPIO_THIRD_DIR_RST,
    common_pu:  TPIO_COMMON_PU_RST,
    rdata:      TPIO_RDATA_RST
  };

endpackage : tpio_pkg

// ===== hw/tpio_pin_bank.sv
`timescale 1ns/1ps
module tpio_pin_bank
  import tpio_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         ce,
  input  wire logic         reset,
  input  wire logic         ext_reset_n,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] data,
  input  wire logic [W-1:0] pu_req,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_pu,
  output logic      [W-1:0] pin_sampled
);

  typedef struct packed {
    logic [W-1:0] oe;
    logic [W-1:0] o;
    logic [W-1:0] pu;
    logic [W-1:0] smp;
  } tpio_bank_state_t;

  tpio_bank_state_t st_reg;
  tpio_bank_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // next pin drive, pull-up and sample
  always_comb begin
    st_next    = st_reg;
    st_next.oe = dir;
    st_next.o  = data & dir;
    st_next.pu = pu_req & ~dir;
    st_next.smp = pin_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // external reset clears drive with no clock edge needed
  // async tri-state
  always_ff @(posedge clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      st_reg <= '0;
    end else if (reset) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign pin_oe      = st_reg.oe;
  assign pin_out     = st_reg.o;
  assign pin_pu      = st_reg.pu;
  assign pin_sampled = st_reg.smp;

endmodule : tpio_pin_bank

// ===== hw/tpio_top.sv
// Functional notes
// - four-line first port, bit 2 output-only
// - first port bits 3,1,0 bidirectional, own pull-ups
// - either reset tri-states every pin; only the external reset is clockless
// - eight input lines, one common pull-up select
// - enabled special function kills that pull-up
// - eight bidirectional third-port lines, per-bit pull-ups
// - low external reset acts without clock
`timescale 1ns/1ps
module tpio_top
  import tpio_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    ce,
  input  wire logic                    reset,
  input  wire logic                    ext_reset_n,
  input  wire tpio_req_t               req,
  output logic      [TPIO_DATA_W-1:0]  rdata,
  input  wire logic [TPIO_FIRST_W-1:0] first_port_lines_in,
  output logic      [TPIO_FIRST_W-1:0] first_port_lines_out,
  output logic      [TPIO_FIRST_W-1:0] first_port_lines_oe,
  output logic      [TPIO_FIRST_W-1:0] first_port_lines_pu,
  output logic                         led_sink_output_line_hc,
  input  wire logic [TPIO_WIDE_W-1:0]  input_only_port_lines_in,
  input  wire logic [TPIO_WIDE_W-1:0]  input_only_special_en,
  output logic      [TPIO_WIDE_W-1:0]  input_only_port_lines_pu,
  input  wire logic [TPIO_WIDE_W-1:0]  third_port_lines_in,
  output logic      [TPIO_WIDE_W-1:0]  third_port_lines_out,
  output logic      [TPIO_WIDE_W-1:0]  third_port_lines_oe,
  output logic      [TPIO_WIDE_W-1:0]  third_port_lines_pu
);

  tpio_regs_t st_reg;
  tpio_regs_t st_next;

  logic [TPIO_FIRST_W-1:0] first_dir;
  logic [TPIO_FIRST_W-1:0] first_pu_req;
  logic [TPIO_FIRST_W-1:0] first_sampled;
  logic [TPIO_WIDE_W-1:0]  input_pu_req;
  logic [TPIO_WIDE_W-1:0]  input_sampled;
  logic [TPIO_WIDE_W-1:0]  third_sampled;

  ////////////////////////////////////////////////////////////////////////////
  // first port steering
  always_comb begin
    first_dir = st_reg.first_ctrl & TPIO_FIRST_BIDIR_MASK;
    first_dir[TPIO_LED_BIT] = 1'b1;
    first_pu_req = st_reg.first_data & TPIO_FIRST_BIDIR_MASK;
  end

  ////////////////////////////////////////////////////////////////////////////
  // input-only port pull-ups: one select, masked by special functions
  always_comb begin
    input_pu_req = {TPIO_WIDE_W{st_reg.common_pu}};
    input_pu_req = input_pu_req & ~input_only_special_en;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes and registered read data
  always_comb begin
    st_next = st_reg;
    if (req.wr) begin
      case (req.addr)
        TPIO_OFS_FIRST_DATA:  st_next.first_data = req.wdata[TPIO_FIRST_W-1:0];
        TPIO_OFS_FIRST_CTRL:  st_next.first_ctrl = req.wdata[TPIO_FIRST_W-1:0];
        TPIO_OFS_THIRD_DATA:  st_next.third_data = req.wdata;
        TPIO_OFS_THIRD_DIR:   st_next.third_dir  = req.wdata;
        TPIO_OFS_PULLUP_CTRL: st_next.common_pu  = req.wdata[TPIO_COMMON_PU_BIT];
        default:              st_next.common_pu  = st_reg.common_pu; // pin and unmapped writes ignored
      endcase
    end
    // read data only meaningful in the cycle after the strobe
    st_next.rdata = '0;
    if (req.rd) begin
      case (req.addr)
        TPIO_OFS_FIRST_DATA:  st_next.rdata = {4'h0, st_reg.first_data};
        TPIO_OFS_FIRST_CTRL:  st_next.rdata = {4'h0, st_reg.first_ctrl};
        // sampled pin levels; led line has no input
        TPIO_OFS_FIRST_PINS:  st_next.rdata = {4'h0, first_sampled & TPIO_FIRST_BIDIR_MASK};
        TPIO_OFS_INPUT_PINS:  st_next.rdata = input_sampled;
        TPIO_OFS_THIRD_DATA:  st_next.rdata = st_reg.third_data;
        TPIO_OFS_THIRD_DIR:   st_next.rdata = st_reg.third_dir;
        TPIO_OFS_THIRD_PINS:  st_next.rdata = third_sampled;
        TPIO_OFS_PULLUP_CTRL: st_next.rdata = {st_reg.common_pu, 7'h00};
        default:              st_next.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control state; external reset needs no clock edge
  // low level resets
  always_ff @(posedge clk or negedge ext_reset_n) begin
    if (!ext_reset_n) begin
      st_reg <= TPIO_REGS_RST;
    end else if (reset) begin
      st_reg <= TPIO_REGS_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign rdata                   = st_reg.rdata;
  // high-current mode is a flop, so it too drops at once on reset
  assign led_sink_output_line_hc = st_reg.first_ctrl[TPIO_HC_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // pin banks; every pad control but the led high-current select leaves from a flop there
  // tri-state on reset
  tpio_pin_bank #(.W(TPIO_FIRST_W)) u_first (
    .clk         (clk),
    .ce          (ce),
    .reset       (reset),
    .ext_reset_n (ext_reset_n),
    .dir         (first_dir),
    .data        (st_reg.first_data),
    .pu_req      (first_pu_req),
    .pin_in      (first_port_lines_in),
    .pin_oe      (first_port_lines_oe),
    .pin_out     (first_port_lines_out),
    .pin_pu      (first_port_lines_pu),
    .pin_sampled (first_sampled)
  );

  // input-only bank: direction tied low, so its drive stays off
  tpio_pin_bank #(.W(TPIO_WIDE_W)) u_input (
    .clk         (clk),
    .ce          (ce),
    .reset       (reset),
    .ext_reset_n (ext_reset_n),
    .dir         ('0),
    .data        ('0),
    .pu_req      (input_pu_req),
    .pin_in      (input_only_port_lines_in),
    .pin_oe      (),
    .pin_out     (),
    .pin_pu      (input_only_port_lines_pu),
    .pin_sampled (input_sampled)
  );

  tpio_pin_bank #(.W(TPIO_WIDE_W)) u_third (
    .clk         (clk),
    .ce          (ce),
    .reset       (reset),
    .ext_reset_n (ext_reset_n),
    .dir         (st_reg.third_dir),
    .data        (st_reg.third_data),
    .pu_req      (st_reg.third_data),
    .pin_in      (third_port_lines_in),
    .pin_oe      (third_port_lines_oe),
    .pin_out     (third_port_lines_out),
    .pin_pu      (third_port_lines_pu),
    .pin_sampled (third_sampled)
  );

endmodule : tpio_top

// ===== verif/tpio_top_props.sv
`timescale 1ns/1ps
module tpio_top_props
  import tpio_pkg::*;
(
  input wire logic       clk,
  input wire logic       ce,
  input wire logic       reset,
  input wire logic       ext_reset_n,
  input wire tpio_req_t  req,
  input wire logic [7:0] rdata,
  input wire logic [3:0] first_port_lines_oe,
  input wire logic [3:0] first_port_lines_pu,
  input wire logic [7:0] input_only_special_en,
  input wire logic [7:0] input_only_port_lines_pu,
  input wire logic [7:0] third_port_lines_oe,
  input wire logic [7:0] third_port_lines_pu
);
  // single domain, either reset parks checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset || !ext_reset_n);
  // direction write accepted
  sequence s_dir_wr;
    ce && req.wr && req.addr == TPIO_OFS_THIRD_DIR;
  endsequence
  // an async release on an edge leaves that edge's flops still held, so skip it
  chk_led_drives: assert property (!reset && ext_reset_n && ce |=> first_port_lines_oe[2])
    else $error("led line idle");
  chk_sync_reset_tri: assert property (disable iff (!ext_reset_n) reset && ce |=>
    first_port_lines_oe == '0 && third_port_lines_oe == '0 && third_port_lines_pu == '0 && rdata == '0)
    else $error("sync reset left drive");
  chk_ext_reset_tri: assert property (disable iff (1'b0) !ext_reset_n |->
    first_port_lines_oe == '0 && third_port_lines_oe == '0 && input_only_port_lines_pu == '0)
    else $error("ext reset left drive");
  chk_special_kills_pu: assert property ($past(ce) |->
    (input_only_port_lines_pu & $past(input_only_special_en)) == '0) else $error("pull-up on special pin");
  chk_common_pu: assert property ($past(ce) && $past(input_only_special_en) == '0 |->
    input_only_port_lines_pu inside {8'h00, 8'hff}) else $error("pull-ups not common");
  chk_pu_undriven: assert property ((third_port_lines_pu & third_port_lines_oe) == '0 &&
    (first_port_lines_pu & first_port_lines_oe) == '0) else $error("pull-up on driven pin");
  chk_rdata_pulse: assert property ($past(ce) && !$past(req.rd) |-> rdata == '0)
    else $error("stray read data");
  chk_dir_to_oe: assert property (s_dir_wr ##1 ce |=> third_port_lines_oe == $past(req.wdata, 2))
    else $error("direction not applied");
endmodule : tpio_top_props

bind tpio_top tpio_top_props tpio_top_props_i (.clk, .ce, .reset, .ext_reset_n, .req, .rdata,
  .first_port_lines_oe, .first_port_lines_pu, .input_only_special_en, .input_only_port_lines_pu,
  .third_port_lines_oe, .third_port_lines_pu);

// ===== verif/tpio_board.sv
`timescale 1ns/1ps
module tpio_board #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] pu,
  input  wire logic [W-1:0] drv,
  input  wire logic         float_en,
  output logic      [W-1:0] pad
);
  logic [W-1:0] flt_reg = '0;
  // a released line toggles every clock so a lost pull-up reads low on alternate cycles
  always @(posedge clk) begin
    flt_reg <= ~flt_reg;
  end
  always_comb begin
    pad = (oe & out) | (~oe & (float_en ? (pu | flt_reg) : drv));
  end
endmodule : tpio_board

// ===== verif/tpio_top_tb.sv
`timescale 1ns/1ps
module tpio_top_tb
  import tpio_pkg::*;
;
  logic       clk = 1'b0;
  logic       ce, reset, ext_reset_n, flt, hc;
  tpio_req_t  req;
  logic [7:0] rdata, se, io_pu, t_out, t_oe, t_pu, t_pad, i_pad, dr2, dr3, fd, fc, td, tdir, cpu;
  logic [3:0] f_out, f_oe, f_pu, f_pad, dr1;
  logic [5:0] ra [9] = '{6'h1b, 6'h1a, 6'h19, 6'h16, 6'h12, 6'h11, 6'h10, 6'h07, 6'h3f};
  int         fail_count = 0;
  int         check_count = 0;
  always #2 clk = ~clk;
  ////////////////////////////////////////
  tpio_top tpio_top_i (.clk, .ce, .reset, .ext_reset_n, .req, .rdata,
    .first_port_lines_in(f_pad), .first_port_lines_out(f_out), .first_port_lines_oe(f_oe),
    .first_port_lines_pu(f_pu), .led_sink_output_line_hc(hc), .input_only_port_lines_in(i_pad),
    .input_only_special_en(se), .input_only_port_lines_pu(io_pu), .third_port_lines_in(t_pad),
    .third_port_lines_out(t_out), .third_port_lines_oe(t_oe), .third_port_lines_pu(t_pu));
  tpio_board #(.W(4)) tpio_board_f_i (.clk, .oe(f_oe), .out(f_out), .pu(f_pu), .drv(dr1), .float_en(flt), .pad(f_pad));
  tpio_board tpio_board_b_i (.clk, .oe('0), .out('0), .pu(io_pu), .drv(dr2), .float_en(flt), .pad(i_pad));
  tpio_board tpio_board_t_i (.clk, .oe(t_oe), .out(t_out), .pu(t_pu), .drv(dr3), .float_en(flt), .pad(t_pad));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clk);
  endtask : rd
  // first port drive: bit2 always out
  function automatic logic [7:0] foe();
    return {4'h0, fc[3], 1'b1, fc[1:0]};
  endfunction : foe
  function automatic logic [7:0] rexp(input logic [5:0] a);
    case (a)
      6'h1b: return fd;
      6'h1a: return fc;
      6'h19: return ((foe() & fd) | (~foe() & dr1)) & 8'h0b;
      6'h16: return dr2;
      6'h12: return td;
      6'h11: return tdir;
      6'h10: return (tdir & td) | (~tdir & dr3);
      6'h07: return cpu;
      default: return 8'h00;
    endcase
  endfunction : rexp
  task automatic mwr(input logic [5:0] a, input logic [7:0] d);
    wr(a, d);
    case (a)
      6'h1b: fd = d & 8'h0f;
      6'h1a: fc = d & 8'h0f;
      6'h12: td = d;
      6'h11: tdir = d;
      6'h07: cpu = d & 8'h80;
      default: ;
    endcase
  endtask : mwr
  task automatic sweep();
    logic [7:0] fe;
    repeat (3) @(posedge clk);
    #1 fe = foe();
    chk(t_oe, tdir);
    chk(t_out & t_oe, td & tdir);
    chk(t_pu, td & ~tdir);
    chk({4'h0, f_oe}, fe);
    chk({f_out & f_oe, f_pu}, {fd[3:0] & fe[3:0], fd[3:0] & ~fc[3:0] & 4'hb});
    chk({7'h0, hc}, {7'h0, fc[2]});
    chk(io_pu, cpu[7] ? ~se : 8'h00);
    @(posedge clk);
    foreach (ra[i]) rd(ra[i], rexp(ra[i]));
  endtask : sweep
  task automatic final_report();
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////
  // reset, released-line corner, random traffic, frozen clock enable, async reset
  initial begin
    void'($urandom(94921));
    {ce, reset, ext_reset_n, flt} = 4'b1110;
    {req, se, dr1, dr2, dr3} = '0;
    {fd, fc, td, tdir, cpu} = '0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    sweep();
    mwr(6'h11, 8'h00);
    mwr(6'h12, 8'hff);
    mwr(6'h07, 8'h80);
    flt <= 1'b1;
    repeat (3) @(posedge clk);
    rd(6'h10, 8'hff);
    rd(6'h16, 8'hff);
    flt <= 1'b0;
    repeat (30) begin
      mwr(ra[$urandom_range(8)], 8'($urandom));
      {dr1, dr2, dr3, se} <= 28'($urandom);
      sweep();
    end
    ce <= 1'b0;
    wr(6'h12, ~td);
    ce <= 1'b1;
    sweep();
    #1 ext_reset_n <= 1'b0;
    #1 chk(t_oe | t_pu | io_pu | {f_oe, f_pu}, 8'h00);
    @(posedge clk);
    ext_reset_n <= 1'b1;
    {fd, fc, td, tdir, cpu} = '0;
    sweep();
    // mid-run synchronous reset while pins are driven and pull-ups are on
    mwr(6'h11, 8'hf0);
    mwr(6'h12, 8'h5a);
    mwr(6'h07, 8'h80);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    {fd, fc, td, tdir, cpu} = '0;
    sweep();
    final_report();
  end
  // hang guard, far past the few microseconds needed
  initial begin
    #100000;
    fail_count++;
    final_report();
  end
endmodule : tpio_top_tb
